// >>> include/shift_mode_regs.vh
`ifndef SHIFT_MODE_REGS_VH
`define SHIFT_MODE_REGS_VH
// Purpose: constants for shift decode, indicator and mode file block
// Assumes: big-endian bit numbering of the documented words is mapped
//          to vector index (width-1-n)
// Notes:   no register offsets exist; registers are reached by micro-ops

// instruction word fields, documented bit n -> index 15-n
`define IW_REG_HI        14
`define IW_REG_LO        12
`define IW_TYPE_HI       7
`define IW_TYPE_LO       4
`define IW_WIDE_CNT_BIT  7
`define IW_TEST_HI       15
`define IW_TEST_LO       12
`define IW_CNT4_HI       3
`define IW_CNT5_HI       4
`define SHIFT_TYPE_DAR16 4'hf
`define COUNT_SRC_REG    3'h1

// indicator byte positions, documented bit n -> index 7-n
`define IND_SUM_EXCESS   7
`define IND_ZERO         6
`define IND_CARRY        5
`define IND_BIT_TEST     4
`define IND_IO_ACCEPT    3
`define IND_GREATER      2
`define IND_LESS         1
`define IND_UNLIKE       0
`define IND_RESET        8'h00

// mode file
`define MODE_ENTRIES     8
`define MODE_DEFAULT_ADR 3'h1
`define MODE_DECIMAL_ADR 3'h3
`define MODE_FLOAT_A_ADR 3'h4
`define MODE_FLOAT_B_ADR 3'h5
`define MODE_RESET       8'h00
`define TRAP_TRACE_BIT   7
`define DEC_EXCESS_BIT   7
`define DEC_CLIP_BIT     6
`define FLT_ROUND_BIT    7
`define FLT_MEM_SIZE_BIT 6
`define FLT_ACC_SIZE_BIT 5
`define FLT_EUM_BIT      4
`define FLT_SEM_BIT      3
`define FLT_PEM_BIT      2

// pending-excess clear encoding
`define CLR_B_FIELD      3'h7

// latches
`define MICROWORD_W      48
`define MONITOR_W        22
`define MONITOR_IRQ_W    8
`define OPTION_W         5
`define OPT_TRANSLATION  0
`define OPT_LONG_ADDR    3
`endif

// >>> testbench/sdsml_properties.sv
// Purpose: port checker for shift decode, indicator and mode file
// Assumes: registered outputs follow their inputs by one clk
// Notes:   sees only the ports of the design top
`timescale 1ns/1ps
module sdsml_props #(
  parameter MW_W  = 48,
  parameter MON_W = 22
) (
  input wire             clk_i,
  input wire             srst_i,
  input wire             cycle_en_i,
  input wire             phase_a_i,
  input wire [15:0]      instr_word_i,
  input wire [15:0]      count_source_register_i,
  input wire             ind_read_op_i,
  input wire             arith_write_i,
  input wire             branch_taken_i,
  input wire [2:0]       a_field_i,
  input wire [2:0]       b_field_i,
  input wire [MW_W-1:0]  store_word_i,
  input wire [MON_W-1:0] monitor_i,
  input wire [2:0]       shift_reg_o,
  input wire [4:0]       shift_count_o,
  input wire             shift_count_from_reg_o,
  input wire [7:0]       indicator_o,
  input wire [15:0]      bus_o,
  input wire             bus_drive_o,
  input wire             trace_trap_o,
  input wire             pending_excess_test_o,
  input wire [7:0]       trap_enable_mode_byte_o,
  input wire [MW_W-1:0]  microword_latch_o,
  input wire [MON_W-1:0] monitor_o,
  input wire             monitor_irq_o
);
  reg        ok_q;
  reg [15:0] iw_q;
  reg [4:0]  cr_q;
  wire [4:0] cf = iw_q[7] ? iw_q[4:0] : {1'b0, iw_q[3:0]};
  // decode outputs lag a clk, so compare against sampled inputs
  always @(posedge clk_i) begin
    ok_q <= !srst_i;
    iw_q <= instr_word_i;
    cr_q <= count_source_register_i[4:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_shift_reg_src: assert property (
    ok_q |-> shift_reg_o == iw_q[14:12]) else $error("operand wrong");
  a_count_field: assert property (
    ok_q && cf != 5'h0 |-> shift_count_o == cf && !shift_count_from_reg_o)
    else $error("count field wrong");
  a_count_from_reg: assert property (
    ok_q && cf == 5'h0 |-> shift_count_from_reg_o && shift_count_o == cr_q)
    else $error("register count wrong");
  a_zero_bit: assert property (
    indicator_o[6] == 1'b0) else $error("zero indicator set");
  a_read_upper_zero: assert property (
    ind_read_op_i |=> bus_drive_o && bus_o[15:8] == 8'h00)
    else $error("indicator read wrong");
  a_trace_trap: assert property (
    cycle_en_i |=> trace_trap_o ==
    (trap_enable_mode_byte_o[7] && $past(branch_taken_i)))
    else $error("trace trap wrong");
  a_pending_clear: assert property (
    cycle_en_i && a_field_i <= 3'h1 && b_field_i == 3'h7 && !arith_write_i
    |-> ##2 !pending_excess_test_o) else $error("pending not cleared");
  a_microword_latch: assert property (
    phase_a_i |=> microword_latch_o == $past(store_word_i))
    else $error("microword not latched");
  a_monitor_latch: assert property (
    !phase_a_i |=> monitor_o == $past(monitor_i))
    else $error("monitor not latched");
  a_monitor_irq_bits: assert property (
    monitor_irq_o == (|monitor_o[7:0])) else $error("monitor irq wrong");
  cover property (shift_count_from_reg_o);
  cover property (trace_trap_o);
  cover property (pending_excess_test_o);
endmodule
bind shift_decode_status_mode_latches sdsml_props #(
  .MW_W(MW_W), .MON_W(MON_W)) sdsml_props_inst (.*);

// >>> testbench/testbench.sv
// Purpose: self-checking bench for shift decode, indicator, mode file
// Assumes: inputs change on the falling clk edge
// Notes:   cycle_en_i held high, so every clk is a microcycle
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] iw;
    logic [2:0]  rg;
    logic [5:0]  cnt;
    logic [1:0]  kind;
  } row_t;
  row_t rows [7] = '{
    '{16'h3003, 3'h3, 6'h03, 2'b00}, '{16'h5070, 3'h5, 6'h33, 2'b10},
    '{16'h70f5, 3'h7, 6'h15, 2'b11}, '{16'h30e0, 3'h3, 6'h33, 2'b10},
    '{16'h2060, 3'h2, 6'h33, 2'b00}, '{16'h5090, 3'h5, 6'h10, 2'b10},
    '{16'h3038, 3'h3, 6'h08, 2'b10}};
  logic [7:0] mv [8] = '{8'h10, 8'h82, 8'h00, 8'hc0, 8'ha4, 8'h58, 0, 0};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] instr_word_i, count_source_register_i, bus_i;
  logic [2:0] rf_addr_i, dest_reg_i, a_field_i, b_field_i;
  logic cycle_en_i, mode_file_load_op_i, mode_file_read_op_i, ind_load_op_i;
  logic ind_read_op_i, alu_excess_i, alu_carry_i, arith_write_i, bit_test_i;
  logic bit_test_we_i, io_accept_i, io_accept_we_i, compare_we_i;
  logic cmp_greater_i, cmp_less_i, cmp_unlike_i, branch_taken_i;
  wire phase_a_i, shift_double_o, shift_dar_long_o, shift_count_from_reg_o;
  wire bus_drive_o, mode_bit_test_flag_o, mode_bit0_sample_flag_o;
  wire trace_trap_o, pending_excess_test_o, software_interrupt_req_o;
  wire monitor_irq_o, translation_unit_option_o, long_address_option_o;
  wire [47:0] store_word_i, microword_latch_o;
  wire [21:0] monitor_i, monitor_o;
  wire [4:0] option_n_i, option_o, shift_count_o;
  wire [2:0] shift_reg_o, shift_pair_reg_o, decimal_enables_o;
  wire [7:0] indicator_o, trap_enable_mode_byte_o;
  wire [15:0] bus_o;
  wire [5:0] float_ctl_a_o, float_ctl_b_o;
  int err_total = 0;
  int check_count = 0;
  always #20 clk_i = ~clk_i;
  shift_decode_status_mode_latches shift_decode_status_mode_latches_inst (.*);
  ucode_status_model ucode_status_model_inst (.clk_i(clk_i),
    .phase_a_o(phase_a_i), .store_word_o(store_word_i),
    .monitor_o(monitor_i), .option_n_o(option_n_i));
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one mode file micro-op: load when ld, else read
  task mop(input logic ld, input logic [2:0] a, input logic [7:0] v);
    mode_file_load_op_i = ld;
    mode_file_read_op_i = !ld;
    rf_addr_i = a;
    bus_i = {8'h00, v};
    tick(1);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
  initial begin
    {instr_word_i, bus_i, rf_addr_i, dest_reg_i, a_field_i, b_field_i} = 0;
    {mode_file_load_op_i, mode_file_read_op_i, ind_load_op_i} = 0;
    {ind_read_op_i, alu_excess_i, alu_carry_i, arith_write_i, bit_test_i} = 0;
    {bit_test_we_i, io_accept_i, io_accept_we_i, compare_we_i} = 0;
    {cmp_greater_i, cmp_less_i, cmp_unlike_i, branch_taken_i} = 0;
    cycle_en_i = 1'b1;
    count_source_register_i = 16'hffd3;
    tick(8);
    srst_i = 1'b0;
    tick(1);
    chk("reset", 16'h0, {indicator_o, trap_enable_mode_byte_o});
    $display("test reset done");
    foreach (rows[i]) begin
      instr_word_i = rows[i].iw;
      tick(1);
      chk("operand", rows[i].rg, shift_reg_o);
      chk("count", rows[i].cnt, {shift_count_from_reg_o, shift_count_o});
      chk("kind", rows[i].kind, {shift_double_o, shift_dar_long_o});
      if (rows[i].kind[1])
        chk("pair", {rows[i].rg[2:1], 1'b0}, shift_pair_reg_o);
    end
    $display("test shift decode done");
    for (int i = 0; i < 8; i++)
      mop(1'b1, i[2:0], mv[i]);
    for (int i = 0; i < 8; i++) begin
      mop(1'b0, i[2:0], 8'h00);
      chk("mode read", {8'h00, mv[i]}, bus_o);
      chk("mode drive", 16'h1, bus_drive_o);
    end
    {mode_file_load_op_i, mode_file_read_op_i} = 2'b00;
    tick(1);
    chk("trap byte", 16'h0082, trap_enable_mode_byte_o);
    chk("dec", 16'h6, decimal_enables_o);
    chk("float", 16'ha56, {float_ctl_a_o, float_ctl_b_o});
    chk("bit0", 16'h1, mode_bit0_sample_flag_o);
    instr_word_i = 16'h6000;
    tick(1);
    chk("bit test 6", 16'h1, mode_bit_test_flag_o);
    instr_word_i = 16'h5000;
    tick(1);
    chk("bit test 5", 16'h0, mode_bit_test_flag_o);
    instr_word_i = 16'he000;
    tick(1);
    chk("bit test e", 16'h0, mode_bit_test_flag_o);
    branch_taken_i = 1'b1;
    tick(1);
    branch_taken_i = 1'b0;
    chk("trace", 16'h1, trace_trap_o);
    $display("test mode file done");
    {arith_write_i, alu_excess_i, alu_carry_i, dest_reg_i} = {3'b111, 3'h5};
    tick(1);
    arith_write_i = 1'b0;
    tick(1);
    chk("unenabled", 16'h0, pending_excess_test_o);
    chk("excess", 16'h5, indicator_o[7:5]);
    {arith_write_i, dest_reg_i} = {1'b1, 3'h6};
    tick(1);
    arith_write_i = 1'b0;
    tick(1);
    chk("pending", 16'h3, {pending_excess_test_o, software_interrupt_req_o});
    {a_field_i, b_field_i} = {3'h1, 3'h7};
    tick(1);
    b_field_i = 3'h0;
    tick(1);
    chk("cleared", 16'h0, pending_excess_test_o);
    {compare_we_i, cmp_greater_i, cmp_unlike_i} = 3'b111;
    {bit_test_we_i, bit_test_i, io_accept_we_i, io_accept_i} = 4'hf;
    tick(1);
    chk("cmp a", 16'hbd, indicator_o);
    {cmp_greater_i, cmp_less_i, cmp_unlike_i, bit_test_i, io_accept_i} = 5'h8;
    tick(1);
    {compare_we_i, bit_test_we_i, io_accept_we_i} = 3'b000;
    chk("cmp b", 16'ha2, indicator_o);
    {ind_load_op_i, bus_i} = {1'b1, 16'hff4b};
    tick(1);
    {ind_load_op_i, ind_read_op_i} = 2'b01;
    tick(1);
    ind_read_op_i = 1'b0;
    chk("ind read", 16'h000b, bus_o);
    chk("options", 16'h29, {translation_unit_option_o, option_o});
    chk("long", 16'h1, long_address_option_o);
    $display("test indicator and options done");
    srst_i = 1'b1;
    tick(1);
    srst_i = 1'b0;
    chk("mid reset", 16'h0, {indicator_o, trap_enable_mode_byte_o});
    chk("reset opt", 16'h0, {translation_unit_option_o, option_o});
    tick(2);
    chk("mode cleared", 16'h0, trap_enable_mode_byte_o);
    chk("opts again", 16'h29, {translation_unit_option_o, option_o});
    $display("test mid-run reset done");
    print_verdict;
  end
endmodule

// >>> testbench/ucode_status_model.sv
// Purpose: microcode store and system status lines facing the block
// Assumes: phase A flips on every falling clk edge
// Notes:   words change each phase so a stuck latch shows up
`timescale 1ns/1ps
module ucode_status_model #(
  parameter MMU_ON  = 1,
  parameter LONG_ON = 1
) (
  input  wire        clk_i,
  output reg         phase_a_o,
  output reg  [47:0] store_word_o,
  output reg  [21:0] monitor_o,
  output reg  [4:0]  option_n_o
);
  reg [15:0] seq_reg = 16'h1234;
  initial begin
    phase_a_o = 1'b0;
    store_word_o = 48'h0;
    monitor_o = 22'h0;
    option_n_o = {1'b1, LONG_ON ? 1'b0 : 1'b1, 2'b11, MMU_ON ? 1'b0 : 1'b1};
  end
  always @(negedge clk_i) begin
    phase_a_o <= ~phase_a_o;
    seq_reg <= seq_reg + 16'h3a5b;
    store_word_o <= {seq_reg, ~seq_reg, seq_reg ^ 16'h5a5a};
    monitor_o <= {seq_reg[5:0], ~seq_reg};
  end
endmodule

// >>> verilog/shift_decode_status_mode_latches.v
// Purpose: shift operand/count decode, indicator byte, 8x8 mode file,
//          bit-test flip-flops, pending-excess trap, control input latches
// Assumes: phase_a_i high marks the phase A high half of a microcycle;
//          cycle_en_i pulses once per microcycle
// Notes:   all outputs registered; decode results valid one clk later
//
// How it works
// - shift register from instruction bits 1-3
// - count bits 12-15 or 11-15 by bit 8
// - zero count takes count from register one
// - double pairs odd with even below, msb even
// - type F is double arithmetic right long
// - indicator byte holds seven flags, zero bit held low
// - excess flag set on register 1-7 overflow
// - compare flags updated by compare micro-ops
// - indicator loads from bus bits 8-15
// - indicator read drives low byte, zeros above
// - eight 8-bit mode entries, load and read
// - mode address from register address low bits
// - mode address defaults to entry one
// - codes 1-7 select mode bit test
// - mode bit zero sampled every cycle
// - trace bit traps every jump or branch
// - enabled register overflow sets pending trap
// - clear op A 0/1, B 7 resets pending
// - float rounding and size bits decoded
// - microword latched during phase A high
// - monitor latched phase A low, irq bits
// - five option bits, option 0 translation
// - option 3 long address when low
`timescale 1ns/1ps
`include "shift_mode_regs.vh"

module shift_decode_status_mode_latches #(
  parameter MW_W  = `MICROWORD_W,
  parameter MON_W = `MONITOR_W,
  parameter OPT_W = `OPTION_W
) (
  input  wire              clk_i,
  input  wire              srst_i,
  input  wire              cycle_en_i,
  input  wire              phase_a_i,
  input  wire [15:0]       instr_word_i,
  input  wire [15:0]       count_source_register_i,
  input  wire [15:0]       bus_i,
  input  wire [2:0]        rf_addr_i,
  input  wire              mode_file_load_op_i,
  input  wire              mode_file_read_op_i,
  input  wire              ind_load_op_i,
  input  wire              ind_read_op_i,
  input  wire              alu_excess_i,
  input  wire              alu_carry_i,
  input  wire              arith_write_i,
  input  wire [2:0]        dest_reg_i,
  input  wire              bit_test_i,
  input  wire              bit_test_we_i,
  input  wire              io_accept_i,
  input  wire              io_accept_we_i,
  input  wire              compare_we_i,
  input  wire              cmp_greater_i,
  input  wire              cmp_less_i,
  input  wire              cmp_unlike_i,
  input  wire              branch_taken_i,
  input  wire [2:0]        a_field_i,
  input  wire [2:0]        b_field_i,
  input  wire [MW_W-1:0]   store_word_i,
  input  wire [MON_W-1:0]  monitor_i,
  input  wire [OPT_W-1:0]  option_n_i,
  output reg  [2:0]        shift_reg_o,
  output reg  [2:0]        shift_pair_reg_o,
  output reg               shift_double_o,
  output reg               shift_dar_long_o,
  output reg  [4:0]        shift_count_o,
  output reg               shift_count_from_reg_o,
  output reg  [7:0]        indicator_o,
  output reg  [15:0]       bus_o,
  output reg               bus_drive_o,
  output reg               mode_bit_test_flag_o,
  output reg               mode_bit0_sample_flag_o,
  output reg               trace_trap_o,
  output reg               pending_excess_test_o,
  output reg               software_interrupt_req_o,
  output reg  [7:0]        trap_enable_mode_byte_o,
  output reg  [2:0]        decimal_enables_o,
  output reg  [5:0]        float_ctl_a_o,
  output reg  [5:0]        float_ctl_b_o,
  output reg  [MW_W-1:0]   microword_latch_o,
  output reg  [MON_W-1:0]  monitor_o,
  output reg               monitor_irq_o,
  output reg  [OPT_W-1:0]  option_o,
  output reg               translation_unit_option_o,
  output reg               long_address_option_o
);

  reg  [7:0] mode_file_reg [0:`MODE_ENTRIES-1];
  reg  [7:0] indicator_reg;
  reg  [7:0] indicator_next;
  reg        pending_reg;
  reg  [2:0] mode_addr;
  reg  [7:0] mode_sel;
  reg  [4:0] count_field;
  reg  [3:0] type_code;
  reg        dbl;
  reg  [2:0] tcode;
  wire       pend_clr;
  wire       pend_set;
  integer    k;

  // type codes 3,7 and 8..f are double-word shifts
  function is_double;
    input [3:0] t;
    begin
      is_double = (t == 4'h3) || (t == 4'h7) || t[3];
    end
  endfunction

  // extracts the shift/entry bit at documented position p of a byte
  function bit_at;
    input [7:0] b;
    input [2:0] p;
    begin
      bit_at = b[3'h7 - p];
    end
  endfunction

  always @* begin
    if (mode_file_load_op_i || mode_file_read_op_i)
      mode_addr = rf_addr_i;
    else
      mode_addr = `MODE_DEFAULT_ADR;
    mode_sel  = mode_file_reg[mode_addr];
    type_code = instr_word_i[`IW_TYPE_HI:`IW_TYPE_LO];
    dbl       = is_double(type_code);
    if (instr_word_i[`IW_WIDE_CNT_BIT])
      count_field = instr_word_i[`IW_CNT5_HI:0];
    else
      count_field = {1'b0, instr_word_i[`IW_CNT4_HI:0]};
    tcode = instr_word_i[`IW_TEST_HI - 1:`IW_TEST_LO];
  end

  assign pend_clr = (a_field_i[2:1] == 2'b00) && (b_field_i == `CLR_B_FIELD);
  assign pend_set = cycle_en_i && arith_write_i && alu_excess_i &&
                    (dest_reg_i != 3'h0) &&
                    bit_at(mode_file_reg[`MODE_DEFAULT_ADR], dest_reg_i);

  always @* begin
    indicator_next = indicator_reg;
    if (ind_load_op_i)
      indicator_next = bus_i[7:0];
    if (arith_write_i && alu_excess_i && dest_reg_i != 3'h0)
      indicator_next[`IND_SUM_EXCESS] = 1'b1;
    if (arith_write_i)
      indicator_next[`IND_CARRY] = alu_carry_i;
    if (bit_test_we_i)
      indicator_next[`IND_BIT_TEST] = bit_test_i;
    if (io_accept_we_i)
      indicator_next[`IND_IO_ACCEPT] = io_accept_i;
    if (compare_we_i) begin
      indicator_next[`IND_GREATER] = cmp_greater_i;
      indicator_next[`IND_LESS]    = cmp_less_i;
      indicator_next[`IND_UNLIKE]  = cmp_unlike_i;
    end
    indicator_next[`IND_ZERO] = 1'b0;
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      for (k = 0; k < `MODE_ENTRIES; k = k + 1)
        mode_file_reg[k] <= `MODE_RESET;
      indicator_reg            <= `IND_RESET;
      pending_reg              <= 1'b0;
      shift_reg_o              <= 3'h0;
      shift_pair_reg_o         <= 3'h0;
      shift_double_o           <= 1'b0;
      shift_dar_long_o         <= 1'b0;
      shift_count_o            <= 5'h00;
      shift_count_from_reg_o   <= 1'b0;
      indicator_o              <= `IND_RESET;
      bus_o                    <= 16'h0000;
      bus_drive_o              <= 1'b0;
      mode_bit_test_flag_o     <= 1'b0;
      mode_bit0_sample_flag_o  <= 1'b0;
      trace_trap_o             <= 1'b0;
      pending_excess_test_o    <= 1'b0;
      software_interrupt_req_o <= 1'b0;
      trap_enable_mode_byte_o  <= `MODE_RESET;
      decimal_enables_o        <= 3'h0;
      float_ctl_a_o            <= 6'h00;
      float_ctl_b_o            <= 6'h00;
      microword_latch_o        <= {MW_W{1'b0}};
      monitor_o                <= {MON_W{1'b0}};
      monitor_irq_o            <= 1'b0;
      option_o                 <= {OPT_W{1'b0}};
      translation_unit_option_o <= 1'b0;
      long_address_option_o    <= 1'b0;
    end else begin
      shift_reg_o    <= instr_word_i[`IW_REG_HI:`IW_REG_LO];
      // even partner below odd; relies on odd operand
      shift_pair_reg_o <= {instr_word_i[`IW_REG_HI:`IW_REG_LO + 1], 1'b0};
      shift_double_o <= dbl;
      shift_dar_long_o <= (type_code == `SHIFT_TYPE_DAR16);
      if (count_field == 5'h00) begin
        shift_count_o          <= count_source_register_i[4:0];
        shift_count_from_reg_o <= 1'b1;
      end else begin
        shift_count_o          <= count_field;
        shift_count_from_reg_o <= 1'b0;
      end
      if (cycle_en_i) begin
        indicator_reg <= indicator_next;
        indicator_o   <= indicator_next;
        if (mode_file_load_op_i)
          mode_file_reg[rf_addr_i] <= bus_i[7:0];
        // bit test flag
        // codes 8-f carry no bit number, so they never set the flag
        mode_bit_test_flag_o <= !instr_word_i[`IW_TEST_HI] &&
          (tcode != 3'h0) && bit_at(mode_sel, tcode);
        mode_bit0_sample_flag_o <= bit_at(mode_sel, 3'h0);
        trace_trap_o <= branch_taken_i &&
          mode_file_reg[`MODE_DEFAULT_ADR][`TRAP_TRACE_BIT];
      end
      // indicator and mode reads onto bus
      bus_drive_o <= ind_read_op_i || mode_file_read_op_i;
      if (ind_read_op_i)
        bus_o <= {8'h00, indicator_reg};
      else if (mode_file_read_op_i)
        bus_o <= {8'h00, mode_sel};
      else
        bus_o <= 16'h0000;
      if (pend_set)
        pending_reg <= 1'b1;
      else if (cycle_en_i && pend_clr)
        pending_reg <= 1'b0;
      pending_excess_test_o    <= pending_reg;
      software_interrupt_req_o <= pending_reg;
      trap_enable_mode_byte_o  <= mode_file_reg[`MODE_DEFAULT_ADR];
      decimal_enables_o <= {
        mode_file_reg[`MODE_DECIMAL_ADR][`DEC_EXCESS_BIT],
        mode_file_reg[`MODE_DECIMAL_ADR][`DEC_CLIP_BIT], 1'b0};
      float_ctl_a_o <= mode_file_reg[`MODE_FLOAT_A_ADR][7:2];
      float_ctl_b_o <= mode_file_reg[`MODE_FLOAT_B_ADR][7:2];
      if (phase_a_i)
        microword_latch_o <= store_word_i;
      if (!phase_a_i) begin
        monitor_o     <= monitor_i;
        monitor_irq_o <= |monitor_i[`MONITOR_IRQ_W-1:0];
      end
      if (phase_a_i) begin
        option_o <= ~option_n_i;
        translation_unit_option_o <= ~option_n_i[`OPT_TRANSLATION];
        long_address_option_o <= ~option_n_i[`OPT_LONG_ADDR];
      end
    end
  end

endmodule
